// [bram_pkg.sv]
// shared constants, types and register map of the 4 kbit embedded block memory
package bram_pkg;

    localparam int WORD_W = 16;
    localparam int ROW_W  = 8;
    localparam int ROWS   = 256;
    localparam int LOC_W  = 11;
    localparam int LANE_W = 3;
    localparam int BUS_W  = 32;
    localparam int ADR_W  = 8;

    typedef enum logic [1:0] {
        SHAPE_256X16  = 2'h0,
        SHAPE_512X8   = 2'h1,
        SHAPE_1024X4  = 2'h2,
        SHAPE_2048X2  = 2'h3
    } bram_shape_t;

    localparam logic [ADR_W-1:0] ADR_CTRL  = 8'h00;
    localparam logic [ADR_W-1:0] ADR_LOC   = 8'h04;
    localparam logic [ADR_W-1:0] ADR_DATA  = 8'h08;
    localparam logic [ADR_W-1:0] ADR_RWORD = 8'h0C;

    localparam int CTRL_SHAPE_LSB   = 0;
    localparam int CTRL_WFALL_BIT   = 2;
    localparam int CTRL_RFALL_BIT   = 3;
    localparam int CTRL_PRELOAD_BIT = 4;

    localparam bram_shape_t      SHAPE_RESET   = SHAPE_256X16;
    localparam logic             WFALL_RESET   = 1'b0;
    localparam logic             RFALL_RESET   = 1'b0;
    localparam logic             PRELOAD_RESET = 1'b0;
    localparam logic [ROW_W-1:0] LOC_RESET     = 8'h00;

    // user port pins as one bundle, so both synchroniser stages stay aligned
    typedef struct packed {
        logic              wclk;
        logic              wgate;
        logic              wstrobe;
        logic [LOC_W-1:0]  wloc;
        logic [WORD_W-1:0] wword;
        logic [WORD_W-1:0] wmask;
        logic              rclk;
        logic              rgate;
        logic              rstrobe;
        logic [LOC_W-1:0]  rloc;
    } bram_pins_t;

endpackage

// [bram_core.sv]
// 256 x 16 storage array with per-bit write and registered read
`timescale 1ns/1ps
module bram_core
    import bram_pkg::*;
#(
    parameter int ROWS_P = ROWS,
    parameter int WIDTH_P = WORD_W
)(
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       wr_en_i,
    input  wire logic [$clog2(ROWS_P)-1:0]  wr_row_i,
    input  wire logic [WIDTH_P-1:0]         wr_data_i,
    input  wire logic [WIDTH_P-1:0]         wr_bits_i,
    input  wire logic                       rd_en_i,
    input  wire logic [$clog2(ROWS_P)-1:0]  rd_row_i,
    output logic      [WIDTH_P-1:0]         rd_word_o
);

    typedef struct packed {
        logic [WIDTH_P-1:0] rd_word;
    } bram_core_state_t;

    bram_core_state_t   q_reg;
    bram_core_state_t   q_next;
    logic [WIDTH_P-1:0] mem [ROWS_P];

    // fixed array, same capacity whatever shape the wrapper presents
    always_ff @(posedge clk_i)
    begin
        if (wr_en_i)
        begin
            for (int b = 0; b < WIDTH_P; b++)
            begin
                if (wr_bits_i[b])
                begin
                    mem[wr_row_i][b] <= wr_data_i[b];
                end
            end
        end
    end

    always_comb
    begin
        q_next = q_reg;
        if (rd_en_i)
        begin
            q_next.rd_word = mem[rd_row_i];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            q_reg <= '0;
        end
        else
        begin
            q_reg <= q_next;
        end
    end

    assign rd_word_o = q_reg.rd_word;

endmodule

// [bram_top.sv]
// block memory top: shaped user ports, edge selection, preload over wishbone
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/1ps
module bram_top
    import bram_pkg::*;
(
    input  wire logic              CLK_I,
    input  wire logic              ARST_N_I,
    input  wire logic [ADR_W-1:0]  ADR_I,
    input  wire logic [BUS_W-1:0]  DAT_I,
    output logic      [BUS_W-1:0]  DAT_O,
    input  wire logic              WE_I,
    input  wire logic [3:0]        SEL_I,
    input  wire logic              STB_I,
    input  wire logic              CYC_I,
    output logic                   ACK_O,
    input  wire logic              WRITE_CLOCK_I,
    input  wire logic              WRITE_CLOCK_GATE_I,
    input  wire logic              WRITE_STROBE_I,
    input  wire logic [LOC_W-1:0]  WRITE_LOCATION_I,
    input  wire logic [WORD_W-1:0] WRITE_WORD_I,
    input  wire logic [WORD_W-1:0] WRITE_MASK_I,
    input  wire logic              READ_CLOCK_I,
    input  wire logic              READ_CLOCK_GATE_I,
    input  wire logic              READ_STROBE_I,
    input  wire logic [LOC_W-1:0]  READ_LOCATION_I,
    output logic      [WORD_W-1:0] READ_WORD_O
);

    typedef struct packed {
        bram_pins_t         s1;
        bram_pins_t         s2;
        logic               wclk_d;
        logic               rclk_d;
        bram_shape_t        shape;
        logic               wfall;
        logic               rfall;
        logic               preload;
        logic [ROW_W-1:0]   init_row;
        logic               w_go;
        logic [ROW_W-1:0]   w_row;
        logic [WORD_W-1:0]  w_data;
        logic [WORD_W-1:0]  w_bits;
        logic               r_go;
        logic [ROW_W-1:0]   r_row;
        logic [LANE_W-1:0]  r_lane;
        bram_shape_t        r_shape;
        logic               r_fill;
        logic [LANE_W-1:0]  r_lane2;
        bram_shape_t        r_shape2;
        logic [WORD_W-1:0]  rword;
        logic               ack;
        logic [BUS_W-1:0]   dat;
    } bram_state_t;

    logic [1:0]        rst_sync_reg;
    logic              rst_n;
    bram_state_t       q_reg;
    bram_state_t       q_next;
    bram_pins_t        pins;
    logic [WORD_W-1:0] core_word;
    logic              w_edge;
    logic              r_edge;
    logic              bus_hit;
    logic              bus_wr;

    // row of a shaped location: the low shape bits pick a lane inside the row
    function automatic logic [ROW_W-1:0] row_of(input logic [LOC_W-1:0] loc,
                                                input bram_shape_t s);
        row_of = ROW_W'(loc >> s);
    endfunction

    function automatic logic [LANE_W-1:0] lane_of(input logic [LOC_W-1:0] loc,
                                                  input bram_shape_t s);
        logic [LANE_W-1:0] m;
        m = LANE_W'((4'h1 << s) - 4'h1);
        lane_of = loc[LANE_W-1:0] & m;
    endfunction

    // log2 of the word width of a shape
    function automatic logic [2:0] lg_of(input bram_shape_t s);
        lg_of = 3'(3'h4 - {1'b0, s});
    endfunction

    // narrow data repeated across all lanes of the row
    function automatic logic [WORD_W-1:0] spread(input logic [WORD_W-1:0] d,
                                                 input bram_shape_t s);
        logic [3:0] dm;
        dm = 4'(4'hF >> s);
        spread = '0;
        for (int b = 0; b < WORD_W; b++)
        begin
            spread[b] = d[4'(b) & dm];
        end
    endfunction

    function automatic logic [WORD_W-1:0] bits_of(input logic [WORD_W-1:0] mask,
                                                  input logic [LOC_W-1:0] loc,
                                                  input bram_shape_t s);
        logic [LANE_W-1:0] ln;
        logic [2:0]        lg;
        ln = lane_of(loc, s);
        lg = lg_of(s);
        bits_of = '0;
        for (int b = 0; b < WORD_W; b++)
        begin
            if (s == SHAPE_256X16)
            begin
                bits_of[b] = ~mask[b];
            end
            else
            begin
                bits_of[b] = ((4'(b) >> lg) == {1'b0, ln});
            end
        end
    endfunction

    function automatic logic [WORD_W-1:0] extract(input logic [WORD_W-1:0] w,
                                                  input logic [LANE_W-1:0] ln,
                                                  input bram_shape_t s);
        logic [3:0] dm;
        logic [3:0] idx;
        dm = 4'(4'hF >> s);
        extract = '0;
        for (int b = 0; b < WORD_W; b++)
        begin
            idx = 4'(({1'b0, ln} << lg_of(s)) + (4'(b) & dm));
            extract[b] = (4'(b) <= dm) ? w[idx] : 1'b0;
        end
    endfunction

    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            rst_sync_reg <= 2'h0;
        end
        else
        begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];

    assign pins.wclk    = WRITE_CLOCK_I;
    assign pins.wgate   = WRITE_CLOCK_GATE_I;
    assign pins.wstrobe = WRITE_STROBE_I;
    assign pins.wloc    = WRITE_LOCATION_I;
    assign pins.wword   = WRITE_WORD_I;
    assign pins.wmask   = WRITE_MASK_I;
    assign pins.rclk    = READ_CLOCK_I;
    assign pins.rgate   = READ_CLOCK_GATE_I;
    assign pins.rstrobe = READ_STROBE_I;
    assign pins.rloc    = READ_LOCATION_I;

    // active edges are found on the second synchroniser stage only
    assign w_edge = q_reg.wfall ? (q_reg.wclk_d & ~q_reg.s2.wclk)
                                : (~q_reg.wclk_d & q_reg.s2.wclk);
    assign r_edge = q_reg.rfall ? (q_reg.rclk_d & ~q_reg.s2.rclk)
                                : (~q_reg.rclk_d & q_reg.s2.rclk);

    assign bus_hit = CYC_I & STB_I & ~q_reg.ack;
    assign bus_wr  = bus_hit & WE_I;

    always_comb
    begin
        q_next        = q_reg;
        q_next.s1     = pins;
        q_next.s2     = q_reg.s1;
        q_next.wclk_d = q_reg.s2.wclk;
        q_next.rclk_d = q_reg.s2.rclk;
        q_next.w_go   = 1'b0;
        q_next.r_go   = 1'b0;
        q_next.r_fill   = q_reg.r_go;
        q_next.r_lane2  = q_reg.r_lane;
        q_next.r_shape2 = q_reg.r_shape;
        q_next.ack    = bus_hit;
        q_next.dat    = '0;

        // user ports are held off while the array is being preloaded
        if (w_edge && q_reg.s2.wgate && q_reg.s2.wstrobe && !q_reg.preload)
        begin
            q_next.w_go   = 1'b1;
            q_next.w_row  = row_of(q_reg.s2.wloc, q_reg.shape);
            q_next.w_data = spread(q_reg.s2.wword, q_reg.shape);
            q_next.w_bits = bits_of(q_reg.s2.wmask, q_reg.s2.wloc, q_reg.shape);
        end

        if (r_edge && q_reg.s2.rgate && q_reg.s2.rstrobe && !q_reg.preload)
        begin
            q_next.r_go    = 1'b1;
            q_next.r_row   = row_of(q_reg.s2.rloc, q_reg.shape);
            q_next.r_lane  = lane_of(q_reg.s2.rloc, q_reg.shape);
            q_next.r_shape = q_reg.shape;
        end

        if (q_reg.r_fill)
        begin
            q_next.rword = extract(core_word, q_reg.r_lane2, q_reg.r_shape2);
        end

        if (bus_hit)
        begin
            case (ADR_I)
                ADR_CTRL:
                begin
                    q_next.dat[CTRL_SHAPE_LSB +: 2]  = q_reg.shape;
                    q_next.dat[CTRL_WFALL_BIT]       = q_reg.wfall;
                    q_next.dat[CTRL_RFALL_BIT]       = q_reg.rfall;
                    q_next.dat[CTRL_PRELOAD_BIT]     = q_reg.preload;
                    if (bus_wr && SEL_I[0])
                    begin
                        q_next.shape   = bram_shape_t'(DAT_I[CTRL_SHAPE_LSB +: 2]);
                        q_next.wfall   = DAT_I[CTRL_WFALL_BIT];
                        q_next.rfall   = DAT_I[CTRL_RFALL_BIT];
                        q_next.preload = DAT_I[CTRL_PRELOAD_BIT];
                    end
                end
                ADR_LOC:
                begin
                    q_next.dat[ROW_W-1:0] = q_reg.init_row;
                    if (bus_wr && SEL_I[0])
                    begin
                        q_next.init_row = DAT_I[ROW_W-1:0];
                    end
                end
                ADR_DATA:
                begin
                    if (bus_wr && q_reg.preload)
                    begin
                        q_next.w_go     = 1'b1;
                        q_next.w_row    = q_reg.init_row;
                        q_next.w_data   = DAT_I[WORD_W-1:0];
                        q_next.w_bits   = {{8{SEL_I[1]}}, {8{SEL_I[0]}}};
                        q_next.init_row = ROW_W'(q_reg.init_row + 8'h01);
                    end
                end
                ADR_RWORD:
                begin
                    q_next.dat[WORD_W-1:0] = q_reg.rword;
                end
                default:
                begin
                    q_next.dat = '0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q_reg          <= '0;
            q_reg.shape    <= SHAPE_RESET;
            q_reg.wfall    <= WFALL_RESET;
            q_reg.rfall    <= RFALL_RESET;
            q_reg.preload  <= PRELOAD_RESET;
            q_reg.init_row <= LOC_RESET;
        end
        else
        begin
            q_reg <= q_next;
        end
    end

    bram_core #(
        .ROWS_P  (ROWS),
        .WIDTH_P (WORD_W)
    ) u_core (
        .clk_i     (CLK_I),
        .rst_n_i   (rst_n),
        .wr_en_i   (q_reg.w_go),
        .wr_row_i  (q_reg.w_row),
        .wr_data_i (q_reg.w_data),
        .wr_bits_i (q_reg.w_bits),
        .rd_en_i   (q_reg.r_go),
        .rd_row_i  (q_reg.r_row),
        .rd_word_o (core_word)
    );

    assign DAT_O       = q_reg.dat;
    assign ACK_O       = q_reg.ack;
    assign READ_WORD_O = q_reg.rword;

endmodule

// [bram_top_sva.sv]
// concurrent checks on the block memory top ports
`timescale 1ns/1ps
module bram_top_sva
    import bram_pkg::*;
(
    input  wire logic              CLK_I,
    input  wire logic              ARST_N_I,
    input  wire logic [ADR_W-1:0]  ADR_I,
    input  wire logic              WE_I,
    input  wire logic              STB_I,
    input  wire logic              CYC_I,
    input  wire logic              ACK_O,
    input  wire logic [BUS_W-1:0]  DAT_O,
    input  wire logic              READ_CLOCK_GATE_I,
    input  wire logic              READ_STROBE_I,
    input  wire logic [WORD_W-1:0] READ_WORD_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    a_ack_one_cycle: assert property (ACK_O |=> !ACK_O)
        else $error("ack held past one cycle");
    a_ack_follows_req: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("request not acked in the next cycle");
    a_ack_has_req: assert property ($rose(ACK_O) |-> $past(CYC_I && STB_I))
        else $error("ack without a request");
    a_dat_idle_zero: assert property (!ACK_O |-> DAT_O == '0)
        else $error("read data not zero outside ack");
    a_unmapped_zero: assert property (ACK_O && $past(!WE_I && ADR_I > 8'h0F) |-> DAT_O == '0)
        else $error("unmapped read not zero");
    a_rword_mirror: assert property (
        ACK_O && $past(!WE_I && ADR_I == ADR_RWORD) |-> DAT_O == {16'h0000, $past(READ_WORD_O)})
        else $error("read word register differs from read port");
    a_rd_gate_hold: assert property (!READ_CLOCK_GATE_I [*8] |=> $stable(READ_WORD_O))
        else $error("read word moved with read gate low");
    a_rd_strobe_hold: assert property (!READ_STROBE_I [*8] |=> $stable(READ_WORD_O))
        else $error("read word moved with read strobe low");
endmodule

bind bram_top bram_top_sva u_sva (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .ADR_I(ADR_I),
    .WE_I(WE_I), .STB_I(STB_I), .CYC_I(CYC_I), .ACK_O(ACK_O), .DAT_O(DAT_O),
    .READ_CLOCK_GATE_I(READ_CLOCK_GATE_I), .READ_STROBE_I(READ_STROBE_I),
    .READ_WORD_O(READ_WORD_O));

// [bram_user.sv]
// fabric-side user logic model driving both memory ports
`timescale 1ns/1ps
module bram_user
    import bram_pkg::*;
(
    input  wire logic              clk_i,
    output logic                   wclk_o,
    output logic                   wgate_o,
    output logic                   wstb_o,
    output logic      [LOC_W-1:0]  wloc_o,
    output logic      [WORD_W-1:0] wword_o,
    output logic      [WORD_W-1:0] wmask_o,
    output logic                   rclk_o,
    output logic                   rgate_o,
    output logic                   rstb_o,
    output logic      [LOC_W-1:0]  rloc_o
);
    initial
    begin
        {wclk_o, wgate_o, wstb_o, wloc_o, wword_o, wmask_o} = '0;
        {rclk_o, rgate_o, rstb_o, rloc_o} = '0;
    end

    // one port clock period; data flips between the edges so the edge choice shows
    task automatic pulse(input logic wr);
        repeat (3) @(posedge clk_i);
        if (wr)
            wclk_o <= 1'b1;
        else
            rclk_o <= 1'b1;
        @(posedge clk_i);
        if (wr)
            {wloc_o, wword_o, wmask_o} <= ~{wloc_o, wword_o, wmask_o};
        else
            rloc_o <= ~rloc_o;
        repeat (3) @(posedge clk_i);
        if (wr)
            wclk_o <= 1'b0;
        else
            rclk_o <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask

    task automatic write_op(input logic [LOC_W-1:0] l, input logic [WORD_W-1:0] d, m,
                            input logic g, s);
        @(posedge clk_i);
        {wloc_o, wword_o, wmask_o, wgate_o, wstb_o} <= {l, d, m, g, s};
        pulse(1'b1);
        {wgate_o, wstb_o} <= 2'b00;
    endtask

    task automatic read_op(input logic [LOC_W-1:0] l, input logic g, s);
        @(posedge clk_i);
        {rloc_o, rgate_o, rstb_o} <= {l, g, s};
        pulse(1'b0);
        {rgate_o, rstb_o} <= 2'b00;
    endtask
endmodule

// [bram_top_bench.sv]
// self-checking bench for the block memory top
`timescale 1ns/1ps
module bram_top_bench
    import bram_pkg::*;
;
    logic              clk = 1'b0;
    logic              arst_n = 1'b0;
    logic [ADR_W-1:0]  adr = '0;
    logic [BUS_W-1:0]  dat = '0;
    logic              we = 1'b0;
    logic              stb = 1'b0;
    logic              cyc = 1'b0;
    logic [3:0]        sel = 4'hf;
    logic [3:0]        wsel = 4'hf;
    logic [BUS_W-1:0]  dat_o;
    logic              ack;
    logic [WORD_W-1:0] rword;
    logic              wclk, wgate, wstb, rclk, rgate, rstb;
    logic [LOC_W-1:0]  wloc, rloc, l;
    logic [WORD_W-1:0] wword, wmask, d, m, last = '0;
    logic [15:0]       mem [ROWS];
    logic [31:0]       seed = 32'h0000_b4fc;
    logic [31:0]       r, q;
    logic [1:0]        shp;
    logic              g, s;
    logic [ADR_W-1:0]  regs [5] = '{ADR_CTRL, ADR_LOC, ADR_DATA, ADR_RWORD, 8'h10};
    int                fail_count = 0;
    int                samples_checked = 0;

    always #50 clk = ~clk;

    bram_top dut (.CLK_I(clk), .ARST_N_I(arst_n), .ADR_I(adr), .DAT_I(dat), .DAT_O(dat_o),
        .WE_I(we), .SEL_I(sel), .STB_I(stb), .CYC_I(cyc), .ACK_O(ack),
        .WRITE_CLOCK_I(wclk), .WRITE_CLOCK_GATE_I(wgate), .WRITE_STROBE_I(wstb),
        .WRITE_LOCATION_I(wloc), .WRITE_WORD_I(wword), .WRITE_MASK_I(wmask),
        .READ_CLOCK_I(rclk), .READ_CLOCK_GATE_I(rgate), .READ_STROBE_I(rstb),
        .READ_LOCATION_I(rloc), .READ_WORD_O(rword));

    bram_user user (.clk_i(clk), .wclk_o(wclk), .wgate_o(wgate), .wstb_o(wstb),
        .wloc_o(wloc), .wword_o(wword), .wmask_o(wmask), .rclk_o(rclk),
        .rgate_o(rgate), .rstb_o(rstb), .rloc_o(rloc));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // bit offset of the lane a location picks in its physical row
    function automatic int sh(logic [1:0] sp, logic [10:0] lc);
        return (16 >> sp) * int'(lc % (11'h1 << sp));
    endfunction

    function automatic logic [15:0] lane(logic [1:0] sp, logic [10:0] lc);
        return 16'(((32'h1 << (16 >> sp)) - 1) << sh(sp, lc));
    endfunction

    // upper location bits pick the row, the lane mux picks the narrow word
    function automatic logic [15:0] rd_exp(logic [1:0] sp, logic [10:0] lc);
        return 16'((mem[8'(lc >> sp)] & lane(sp, lc)) >> sh(sp, lc));
    endfunction

    // the mask only counts in the full-width shape
    function automatic logic [15:0] wr_exp(logic [1:0] sp, logic [10:0] lc,
                                          logic [15:0] dw, logic [15:0] mw);
        logic [15:0] f;
        f = lane(sp, lc) & ~((sp == 2'd0) ? mw : 16'h0000);
        return (mem[8'(lc >> sp)] & ~f) | (16'(32'(dw) << sh(sp, lc)) & f);
    endfunction

    task automatic final_report();
        if (fail_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [BUS_W-1:0] dw,
                      output logic [BUS_W-1:0] rd);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, dw, wsel};
        for (n = 0; n < 20 && ack !== 1'b1; n++)
            @(posedge clk);
        rd = dat_o;
        {cyc, stb} <= 2'b00;
        if (n == 20)
        begin
            fail_count++;
            final_report();
        end
    endtask

    initial
    begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk("read_word", 32'(rword), '0);
        foreach (regs[i])
        begin
            wb(1'b0, regs[i], '0, q);
            chk("reg_reset", q, '0);
        end
        // fill every row through preload, then let the location wrap
        wb(1'b1, ADR_CTRL, 32'h0000_0010, q);
        wb(1'b1, ADR_LOC, '0, q);
        for (int i = 0; i < ROWS; i++)
        begin
            r = rnd();
            mem[i] = r[15:0];
            wb(1'b1, ADR_DATA, r, q);
        end
        wb(1'b0, ADR_LOC, '0, q);
        chk("loc_wrap", q, '0);
        // byte lanes during preload: only the low byte of row 0 moves
        wsel = 4'h1;
        r = rnd();
        wb(1'b1, ADR_DATA, r, q);
        mem[0][7:0] = r[7:0];
        wsel = 4'hf;
        wb(1'b0, ADR_CTRL, '0, q);
        chk("ctrl", q, 32'h0000_0010);
        wb(1'b1, ADR_CTRL, '0, q);
        for (int k = 0; k < 256; k += 255)
        begin
            user.read_op(11'(k), 1'b1, 1'b1);
            last = mem[k];
            chk("rom_word", 32'(rword), 32'(last));
        end
        for (int c = 0; c < 16; c++)
        begin
            shp = 2'(c);
            wb(1'b1, ADR_CTRL, 32'(c), q);
            repeat (4)
            begin
                r = rnd();
                {l, g, s, d} = {r[10:0], |r[12:11], |r[14:13], r[31:16]};
                r = rnd();
                m = r[15:0];
                user.write_op(l, d, m, g, s);
                if (c[2])
                    {l, d, m} = ~{l, d, m};
                if (g && s)
                    mem[8'(l >> shp)] = wr_exp(shp, l, d, m);
                r = rnd();
                if (r[0])
                    l = r[11:1];
                {g, s} = {|r[13:12], |r[15:14]};
                user.read_op(c[3] ? ~l : l, g, s);
                if (g && s)
                    last = rd_exp(shp, l);
                chk("read_word", 32'(rword), 32'(last));
            end
        end
        wb(1'b1, 8'h10, 32'hffff_ffff, q);
        wb(1'b0, ADR_CTRL, '0, q);
        chk("ctrl", q, 32'h0000_000f);
        wb(1'b0, ADR_RWORD, '0, q);
        chk("rword", q, {16'h0000, last});
        final_report();
    end
endmodule
